// ==== core/shp_pins_defs.vh ====
// Constants for the SRAM-like host port pin block
`ifndef SHP_PINS_DEFS_VH
`define SHP_PINS_DEFS_VH
// Wishbone register byte offsets
`define SHP_REG_CTRL 8'h00
`define SHP_REG_STAT 8'h04
`define SHP_REG_INTSTAT 8'h08
`define SHP_REG_INTMASK 8'h0c
`define SHP_REG_IRQCFG 8'h10
`define SHP_REG_MUXCFG 8'h14
`define SHP_REG_LASTACC 8'h18
// Control register fields
`define SHP_CTRL_SLEEP 0
`define SHP_CTRL_GENERAL_OUTPUT_THREE 1
`define SHP_CTRL_GENERAL_OUTPUT_FOUR 2
// Interrupt event bits
`define SHP_EV_READ 0
`define SHP_EV_WRITE 1
`define SHP_EV_WAKE 2
`define SHP_EV_FIFO 3
`define SHP_EV_W 4
// IRQ config fields
`define SHP_IRQ_POL 0
`define SHP_IRQ_OD 1
`define SHP_IRQ_SRC_LO 2
// Pin mux selections
`define SHP_MUX_ROM 2'h0
`define SHP_MUX_GPO 2'h1
`define SHP_MUX_MON_A 2'h2
`define SHP_MUX_MON_B 2'h3
// Host address decode
`define SHP_ADDR_W 7
`define SHP_FIFO_SPAN 7'h20
`define SHP_FIFO_MASK 7'h03
`endif

// ==== core/shp_pins.v ====
// SRAM-like host port pin logic with Wishbone control registers
//
// Function
// - FIFO select forces FIFO window access
// - FIFO mode ignores address bits seven-three
// - Decode seven-bit word address for targets
// - Strobes valid only with select asserted
// - Byte order low means little endian
// - Byte order high means big endian
// - Byte order sampled with qualified strobe
// - Qualified write wakes from reduced power
// - Latch width strap at reset release
// - Wide bus disables upper pull-downs
// - Interrupt polarity, source, driver programmable
// - Data pin: output three or TX monitor
// - Clock pin: output four or RX monitor
// - Data pin reuse holds ROM select inactive
// - Clock pin reuse holds ROM select inactive
// - Outputs three and four never inputs
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "shp_pins_defs.vh"
module shp_pins (
	// Clock and reset
	input wire ref_clk,
	input wire reset,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Host port pins
	input wire [6:0] hostAddr,
	input wire readStrobeN,
	input wire writeStrobeN,
	input wire deviceSelectN,
	input wire fifoSelect,
	input wire byteOrderSelect,
	input wire busWidthStrap,
	input wire [31:0] hostDataIn,
	// Host side decoded access
	output reg hostRdPulse,
	output reg hostWrPulse,
	output reg hostFifoAcc,
	output reg [6:0] hostWordAddr,
	output reg hostBigEndian,
	output reg [31:0] hostWrData,
	output reg wideBus,
	output reg upperPullDownEn,
	// Internal MII monitors
	input wire miiTxEn,
	input wire miiTxClk,
	input wire miiRxDv,
	input wire miiRxClk,
	// Serial ROM path from controller
	input wire romDataOut,
	input wire romDataOe,
	input wire romClock,
	input wire romSelect,
	// Multiplexed pins
	output reg serialRomDataO,
	output reg serialRomDataOe,
	output reg serialRomClock,
	output reg serialRomSelect,
	// Interrupt pin and power state
	output reg irqO,
	output reg irqOe,
	output reg irqInt,
	output reg sleeping
);
	// Synchroniser stages for pin inputs
	reg [6:0] addrS1_q, addrS2_q;
	reg [31:0] dataS1_q, dataS2_q;
	reg [4:0] ctlS1_q, ctlS2_q;
	reg [3:0] miiS1_q, miiS2_q;
	reg strapS1_q, strapS2_q;
	reg rdQual_q, wrQual_q;
	reg strapDone_q;
	// Registers
	reg [2:0] ctrl_q;
	reg [`SHP_EV_W-1:0] intStat_q, intMask_q;
	reg [3:0] irqCfg_q;
	reg [3:0] muxCfg_q;
	reg readSeen_q;
	wire csN, rdN, wrN, fsel, endSel;
	wire rdQual, wrQual, rdEdge, wrEdge;
	wire [6:0] wordAddr;
	wire [31:0] swapped, rawData;
	wire [`SHP_EV_W-1:0] events;
	wire irqSrc, irqActive, wbReq;
	wire [1:0] dataMux, clkMux;
	reg [31:0] rdMux;

	// Two flip-flops ahead of any pin logic
	always @(posedge ref_clk) begin
		addrS1_q <= hostAddr;
		addrS2_q <= addrS1_q;
		dataS1_q <= hostDataIn;
		dataS2_q <= dataS1_q;
		ctlS1_q <= {byteOrderSelect, fifoSelect, deviceSelectN, writeStrobeN, readStrobeN};
		ctlS2_q <= ctlS1_q;
		miiS1_q <= {miiRxClk, miiRxDv, miiTxClk, miiTxEn};
		miiS2_q <= miiS1_q;
		strapS1_q <= busWidthStrap;
		strapS2_q <= strapS1_q;
	end

	assign rdN = ctlS2_q[0];
	assign wrN = ctlS2_q[1];
	assign csN = ctlS2_q[2];
	assign fsel = ctlS2_q[3];
	assign endSel = ctlS2_q[4];
	assign rdQual = ~csN & ~rdN;
	assign wrQual = ~csN & ~wrN;
	assign rdEdge = rdQual & ~rdQual_q;
	assign wrEdge = wrQual & ~wrQual_q;
	assign wordAddr = fsel ? (addrS2_q & `SHP_FIFO_MASK) : addrS2_q;
	assign rawData = wideBus ? dataS2_q : {16'h0000, dataS2_q[15:0]};
	assign swapped = {rawData[7:0], rawData[15:8], rawData[23:16], rawData[31:24]};

	// Host access decode; sampled on the qualified strobe edge
	always @(posedge ref_clk) begin
		if (reset) begin
			rdQual_q <= 1'b0;
			wrQual_q <= 1'b0;
			hostRdPulse <= 1'b0;
			hostWrPulse <= 1'b0;
			hostFifoAcc <= 1'b0;
			hostWordAddr <= 7'h00;
			hostBigEndian <= 1'b0;
			hostWrData <= 32'h00000000;
			readSeen_q <= 1'b0;
		end else begin
			rdQual_q <= rdQual;
			wrQual_q <= wrQual;
			hostRdPulse <= rdEdge;
			// Writes before the first read are dropped, as the host knows
			// read before write
			hostWrPulse <= wrEdge & readSeen_q & ~sleeping;
			if (rdEdge) begin
				readSeen_q <= 1'b1;
			end else if (wrEdge & sleeping) begin
				readSeen_q <= 1'b0;
			end
			if (rdEdge | wrEdge) begin
				hostWordAddr <= wordAddr;
				hostFifoAcc <= fsel | (wordAddr < `SHP_FIFO_SPAN);
				hostBigEndian <= endSel;
				hostWrData <= endSel ? swapped : rawData;
			end
		end
	end

	// Strap capture one cycle after reset release, never under reset
	always @(posedge ref_clk) begin
		if (reset) begin
			strapDone_q <= 1'b0;
		end else begin
			strapDone_q <= 1'b1;
		end
	end
	always @(posedge ref_clk) begin
		if (reset) begin
			wideBus <= 1'b0;
			upperPullDownEn <= 1'b1;
		end else if (!strapDone_q) begin
			wideBus <= strapS2_q;
			upperPullDownEn <= ~strapS2_q;
		end
	end

	// Events: host read, host write, wake, FIFO access
	assign events = {(rdEdge | wrEdge) & fsel, wrEdge & sleeping, wrEdge, rdEdge};
	assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// Wishbone register writes, one-cycle ack
	always @(posedge ref_clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			ctrl_q <= 3'h0;
			intStat_q <= 4'h0;
			intMask_q <= 4'h0;
			irqCfg_q <= 4'h0;
			muxCfg_q <= 4'h0;
			sleeping <= 1'b0;
		end else begin
			wb_ack_o <= wbReq;
			// Set beats clear so no event is lost
			intStat_q <= (intStat_q & ~((wbReq && wb_we_i && wb_sel_i[0] &&
				wb_adr_i == `SHP_REG_INTSTAT) ? wb_dat_i[3:0] : 4'h0)) | events;
			if (wrEdge & sleeping) begin
				sleeping <= 1'b0;
			end else if (wbReq && wb_we_i && wb_sel_i[0] && wb_adr_i == `SHP_REG_CTRL &&
				wb_dat_i[`SHP_CTRL_SLEEP]) begin
				sleeping <= 1'b1;
			end
			if (wbReq && wb_we_i && wb_sel_i[0]) begin
				if (wb_adr_i == `SHP_REG_CTRL) begin
					ctrl_q <= wb_dat_i[2:0];
				end else if (wb_adr_i == `SHP_REG_INTMASK) begin
					intMask_q <= wb_dat_i[3:0];
				end else if (wb_adr_i == `SHP_REG_IRQCFG) begin
					irqCfg_q <= wb_dat_i[3:0];
				end else if (wb_adr_i == `SHP_REG_MUXCFG) begin
					muxCfg_q <= wb_dat_i[3:0];
				end
			end
		end
	end

	// Read mux; unmapped reads return zero
	always @* begin
		rdMux = 32'h00000000;
		if (wb_adr_i == `SHP_REG_CTRL) begin
			rdMux = {29'h0, ctrl_q[2:1], sleeping};
		end else if (wb_adr_i == `SHP_REG_STAT) begin
			rdMux = {27'h0, readSeen_q, hostBigEndian, hostFifoAcc, upperPullDownEn, wideBus};
		end else if (wb_adr_i == `SHP_REG_INTSTAT) begin
			rdMux = {28'h0, intStat_q};
		end else if (wb_adr_i == `SHP_REG_INTMASK) begin
			rdMux = {28'h0, intMask_q};
		end else if (wb_adr_i == `SHP_REG_IRQCFG) begin
			rdMux = {28'h0, irqCfg_q};
		end else if (wb_adr_i == `SHP_REG_MUXCFG) begin
			rdMux = {28'h0, muxCfg_q};
		end else if (wb_adr_i == `SHP_REG_LASTACC) begin
			rdMux = {25'h0, hostWordAddr};
		end
	end
	always @(posedge ref_clk) begin
		if (reset) begin
			wb_dat_o <= 32'h00000000;
		end else if (wbReq) begin
			wb_dat_o <= rdMux;
		end
	end

	// source select: all masked events or wake only
	assign irqSrc = irqCfg_q[`SHP_IRQ_SRC_LO] ? (intStat_q[`SHP_EV_WAKE] & intMask_q[`SHP_EV_WAKE])
		: |(intStat_q & intMask_q);
	assign irqActive = irqSrc;
	// Interrupt pin; open drain only drives the active level
	always @(posedge ref_clk) begin
		if (reset) begin
			irqInt <= 1'b0;
			irqO <= 1'b0;
			irqOe <= 1'b0;
		end else begin
			irqInt <= |(intStat_q & intMask_q);
			irqO <= irqActive ~^ irqCfg_q[`SHP_IRQ_POL];
			irqOe <= irqCfg_q[`SHP_IRQ_OD] ? irqActive : 1'b1;
		end
	end

	assign dataMux = muxCfg_q[1:0];
	assign clkMux = muxCfg_q[3:2];
	// Pin muxing; pins are output-only when reused, there is no input path
	always @(posedge ref_clk) begin
		if (reset) begin
			serialRomDataO <= 1'b0;
			serialRomDataOe <= 1'b0;
			serialRomClock <= 1'b0;
			serialRomSelect <= 1'b0;
		end else begin
			case (dataMux)
				`SHP_MUX_ROM: begin
					serialRomDataO <= romDataOut;
					serialRomDataOe <= romDataOe;
				end
				`SHP_MUX_GPO: begin
					serialRomDataO <= ctrl_q[`SHP_CTRL_GENERAL_OUTPUT_THREE];
					serialRomDataOe <= 1'b1;
				end
				`SHP_MUX_MON_A: begin
					serialRomDataO <= miiS2_q[0];
					serialRomDataOe <= 1'b1;
				end
				default: begin
					serialRomDataO <= miiS2_q[1];
					serialRomDataOe <= 1'b1;
				end
			endcase
			case (clkMux)
				`SHP_MUX_ROM: serialRomClock <= romClock;
				`SHP_MUX_GPO: serialRomClock <= ctrl_q[`SHP_CTRL_GENERAL_OUTPUT_FOUR];
				`SHP_MUX_MON_A: serialRomClock <= miiS2_q[2];
				default: serialRomClock <= miiS2_q[3];
			endcase
			serialRomSelect <= (dataMux == `SHP_MUX_ROM && clkMux == `SHP_MUX_ROM) ?
				romSelect : 1'b0;
		end
	end
endmodule

// ==== dv/shp_pins_monitor.sv ====
// Assertion checker for the host port pin block
`timescale 1ns/10ps
`include "shp_pins_defs.vh"
module shp_pins_monitor (
	// Clock, reset and register bus
	input logic ref_clk,
	input logic reset,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	input logic wb_ack_o,
	// Host pins and decoded results
	input logic readStrobeN,
	input logic writeStrobeN,
	input logic deviceSelectN,
	input logic hostRdPulse,
	input logic hostWrPulse,
	input logic hostFifoAcc,
	input logic [6:0] hostWordAddr,
	input logic [31:0] hostWrData,
	input logic wideBus,
	input logic upperPullDownEn,
	// Shared pins and interrupt
	input logic serialRomSelect,
	input logic irqO,
	input logic irqOe,
	input logic irqInt,
	input logic sleeping
);
	logic [3:0] muxQ;
	logic [2:0] cfgQ;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Shadow copies, updated on the ack edge, one edge after the register write lands
	always @(posedge ref_clk) begin
		if (reset) begin
			muxQ <= 4'h0;
			cfgQ <= 3'h0;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]) begin
			if (wb_adr_i == `SHP_REG_MUXCFG) muxQ <= wb_dat_i[3:0];
			if (wb_adr_i == `SHP_REG_IRQCFG) cfgQ <= wb_dat_i[2:0];
		end
	end
	// Qualified strobe starts, seen on the raw pins
	sequence rdStart;
		$rose(!deviceSelectN && !readStrobeN);
	endsequence
	sequence wrStart;
		$rose(!deviceSelectN && !writeStrobeN);
	endsequence
	chk_read_pulse: assert property (rdStart |-> ##[2:4] hostRdPulse)
		else $error("read strobe not answered");
	chk_select_qual: assert property (deviceSelectN [*5] |-> !hostRdPulse && !hostWrPulse)
		else $error("access without select");
	chk_fifo_decode: assert property ((hostRdPulse || hostWrPulse) |-> hostFifoAcc == (hostWordAddr < 7'h20))
		else $error("target decode wrong");
	chk_wake_write: assert property (sleeping ##0 wrStart |-> ##[2:5] !sleeping)
		else $error("no wake on write");
	chk_narrow_data: assert property (hostWrPulse && !wideBus |-> hostWrData[31:16] == 16'h0)
		else $error("upper lines used when narrow");
	chk_pull_down: assert property ($stable(wideBus) |-> upperPullDownEn != wideBus)
		else $error("pull-down state wrong");
	chk_rom_select: assert property ($stable(muxQ) && muxQ != 4'h0 |-> !serialRomSelect)
		else $error("rom select active while pin reused");
	chk_irq_drive: assert property ($stable(cfgQ) && cfgQ[2:1] == 2'h0 && !$past(reset) |-> irqOe && irqO == (irqInt == cfgQ[0]))
		else $error("interrupt pin level wrong");
endmodule
bind shp_pins shp_pins_monitor chk (.*);

// ==== dv/shp_host_model.sv ====
// Host CPU bus controller model driving the port pins
`timescale 1ns/10ps
module shp_host_model #(
	parameter logic [6:0] BYTE_TEST_ADDR = 7'h32
) (
	// Clock
	input logic ref_clk,
	// Host port pins
	output logic [6:0] hostAddr,
	output logic readStrobeN,
	output logic writeStrobeN,
	output logic deviceSelectN,
	output logic fifoSelect,
	output logic byteOrderSelect,
	output logic [31:0] hostDataIn
);
	// Idle bus at time zero
	initial begin
		{readStrobeN, writeStrobeN, deviceSelectN} = 3'h7;
		{hostAddr, fifoSelect, byteOrderSelect, hostDataIn} = 41'h0;
	end
	task automatic access(input logic wr, input logic [6:0] a, input logic [31:0] d,
		input logic fs, input logic be);
		@(posedge ref_clk);
		{hostAddr, fifoSelect, byteOrderSelect, hostDataIn} <= {a, fs, be, d};
		deviceSelectN <= 1'h0;
		writeStrobeN <= !wr;
		readStrobeN <= wr;
		repeat (6) @(posedge ref_clk);
		{readStrobeN, writeStrobeN, deviceSelectN} <= 3'h7;
		// Released lines change pattern so a stale value cannot pass
		{hostAddr, hostDataIn} <= {~a, ~d};
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic wake();
		access(1'h1, BYTE_TEST_ADDR, 32'h0, 1'h0, 1'h0);
		access(1'h0, BYTE_TEST_ADDR, 32'h0, 1'h0, 1'h0);
	endtask
endmodule

// ==== dv/shp_pins_test.sv ====
// Self-checking bench for the host port pin block
`timescale 1ns/10ps
`include "shp_pins_defs.vh"
module shp_pins_test;
	logic ref_clk = 1'h0, reset = 1'h1, busWidthStrap = 1'h0;
	logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h0;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, hostDataIn, hostWrData, rdat;
	logic readStrobeN, writeStrobeN, deviceSelectN, fifoSelect, byteOrderSelect;
	logic [6:0] hostAddr, hostWordAddr;
	logic hostRdPulse, hostWrPulse, hostFifoAcc, hostBigEndian, wideBus, upperPullDownEn;
	logic miiTxEn = 1'h0, miiTxClk = 1'h0, miiRxDv = 1'h0, miiRxClk = 1'h0;
	logic romDataOut = 1'h0, romDataOe = 1'h0, romClock = 1'h0, romSelect = 1'h0;
	logic serialRomDataO, serialRomDataOe, serialRomClock, serialRomSelect;
	logic irqO, irqOe, irqInt, sleeping;
	int err_total = 0, n_checks = 0, wrCnt = 0, rdCnt = 0, cycles = 0;
	shp_pins DUT (.*);
	shp_host_model host (.*);
	always #50 ref_clk = ~ref_clk;
	// Count accepted accesses; the cycle ceiling cuts a hang short
	always @(posedge ref_clk) begin
		rdCnt <= rdCnt + hostRdPulse;
		wrCnt <= wrCnt + hostWrPulse;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Classic single cycle; extra idle edges let outputs settle
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge ref_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 50);
		rdat = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		if (n == 50) err_total++;
		repeat (3) @(posedge ref_clk);
	endtask
	// Early write refused, then narrow little-endian write
	task automatic t_narrow();
		chk({wideBus, upperPullDownEn}, 2'h1);
		host.access(1'h1, 7'h25, 32'h11223344, 1'h0, 1'h0);
		chk(wrCnt, 32'h0);
		host.access(1'h0, 7'h25, 32'h0, 1'h0, 1'h0);
		host.access(1'h1, 7'h25, 32'h11223344, 1'h0, 1'h0);
		chk({wrCnt[3:0], rdCnt[3:0]}, 8'h11);
		chk(hostWrData, 32'h3344);
		chk({hostBigEndian, hostFifoAcc, hostWordAddr}, 9'h25);
	endtask
	// Window select forces the FIFO target and masks upper bits
	task automatic t_fifo();
		host.access(1'h0, 7'h7e, 32'h0, 1'h1, 1'h0);
		chk({hostFifoAcc, hostWordAddr}, 8'h82);
		host.access(1'h0, 7'h1f, 32'h0, 1'h0, 1'h0);
		chk({hostFifoAcc, hostWordAddr}, 8'h9f);
		host.access(1'h0, 7'h40, 32'h0, 1'h0, 1'h0);
		chk({hostFifoAcc, hostWordAddr}, 8'h40);
	endtask
	// Every pin-share mode with both monitor levels
	task automatic t_mux();
		logic [3:0] dv, cv, got;
		wb(1'h1, `SHP_REG_CTRL, 32'h2);
		for (int p = 0; p < 2; p++) begin
			{miiTxEn, miiRxClk, romDataOut} <= {3{p[0]}};
			{miiTxClk, miiRxDv, romClock, romSelect, romDataOe} <= {5{!p[0]}};
			for (int s = 0; s < 4; s++) begin
				wb(1'h1, `SHP_REG_MUXCFG, {s[1:0], s[1:0]});
				dv = {miiTxClk, miiTxEn, 1'h1, romDataOut};
				cv = {miiRxClk, miiRxDv, 1'h0, romClock};
				got = {serialRomDataOe, serialRomSelect, serialRomClock, serialRomDataO};
				chk(got, {s ? 2'h2 : {romDataOe, romSelect}, cv[s], dv[s]});
			end
		end
	endtask
	// Sleep, wake by write, interrupt mask, polarity, source, driver
	task automatic t_sleep_irq();
		wb(1'h1, `SHP_REG_INTSTAT, 32'hf);
		wb(1'h1, `SHP_REG_IRQCFG, 32'h1);
		wb(1'h1, `SHP_REG_INTMASK, 32'h4);
		wb(1'h1, `SHP_REG_CTRL, 32'h1);
		chk({sleeping, irqInt}, 2'h2);
		host.wake();
		chk({sleeping, irqInt, irqO, irqOe, wrCnt[3:0]}, 8'h71);
		wb(1'h1, `SHP_REG_IRQCFG, 32'h0);
		chk({irqInt, irqO, irqOe}, 3'h5);
		wb(1'h1, `SHP_REG_INTMASK, 32'h1);
		wb(1'h1, `SHP_REG_IRQCFG, 32'h5);
		chk(irqO, 1'h0);
		wb(1'h1, `SHP_REG_IRQCFG, 32'h3);
		chk(irqOe, 1'h1);
		wb(1'h1, `SHP_REG_INTSTAT, 32'hf);
		chk({irqInt, irqOe}, 2'h0);
		// Last host access was the read at the byte-order test address
		wb(1'h0, `SHP_REG_LASTACC, 32'h0);
		chk(rdat, 32'h32);
		wb(1'h0, 8'h40, 32'h0);
		chk(rdat, 32'h0);
	endtask
	// Wide strap at a second reset, big-endian write
	task automatic t_wide();
		{busWidthStrap, reset} <= 2'h3;
		repeat (20) @(posedge ref_clk);
		reset <= 1'h0;
		repeat (3) @(posedge ref_clk);
		chk({wideBus, upperPullDownEn}, 2'h2);
		host.access(1'h0, 7'h25, 32'h0, 1'h0, 1'h1);
		host.access(1'h1, 7'h25, 32'h11223344, 1'h0, 1'h1);
		chk(hostWrData, 32'h44332211);
		chk(hostBigEndian, 1'h1);
		// Status: read seen, big endian, register target, pull-downs off, wide
		wb(1'h0, `SHP_REG_STAT, 32'h0);
		chk(rdat, 32'h19);
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'h0;
		repeat (3) @(posedge ref_clk);
		t_narrow();
		t_fifo();
		t_mux();
		t_sleep_irq();
		t_wide();
		tally_and_finish();
	end
endmodule
